// >>> src/six_source_vectored_irq_unit.sv
// six-source vectored interrupt unit: control registers, pending flags,
// fixed-priority selection and vector call towards the program sequencer
// assumes the sequencer pushes the pc on call and reports stack depth
`timescale 1ns/10ps
module six_source_vectored_irq_unit
	import irq_unit_pkg::*;
#(
	parameter int DEPTH = STACK_LEVELS
)(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire mem_req_t memReq,
	output logic [7:0] rdData,
	output logic rdHit,
	input wire logic extPinZero,
	input wire logic extPinOne,
	input wire logic [1:0] extZeroEdgeSel,
	input wire logic [1:0] extOneEdgeSel,
	input wire logic timerOvf,
	input wire logic timebaseTimeout,
	input wire logic adcDone,
	input wire logic rtcTimeout,
	input wire logic interruptExitInstr,
	input wire logic subroutineExitInstr,
	input wire logic [3:0] stackDepth,
	input wire logic halted,
	output irq_call_t irqCall,
	output logic wakeUp,
	output logic phaseTwoClock,
	output logic [1:0] phase
);
	// ****************************************************************
	// phase generator
	// ****************************************************************
	logic [1:0] phase_r;
	// one instruction cycle is four system clocks
	always_ff @(posedge clk_sys or negedge rst_n)
		if (!rst_n)
			phase_r <= 2'h0;
		else
			phase_r <= phase_r + 2'h1;
	assign phase = phase_r;
	wire isPhaseTwo = (phase_r == PHASE_TWO);
	assign phaseTwoClock = isPhaseTwo;

	// ****************************************************************
	// pin synchronisers and edge detection
	// ****************************************************************
	logic [1:0] pinMeta_r, pinSync_r, pinOld_r;
	always_ff @(posedge clk_sys or negedge rst_n)
		if (!rst_n)
		begin
			pinMeta_r <= 2'h0;
			pinSync_r <= 2'h0;
			pinOld_r <= 2'h0;
		end
		else
		begin
			pinMeta_r <= {extPinOne, extPinZero};
			pinSync_r <= pinMeta_r;
			pinOld_r <= pinSync_r;
		end
	// edge select bit 0 picks falling, bit 1 picks rising
	wire ext0Fall = pinOld_r[0] & ~pinSync_r[0];
	wire ext0Rise = ~pinOld_r[0] & pinSync_r[0];
	wire ext1Fall = pinOld_r[1] & ~pinSync_r[1];
	wire ext1Rise = ~pinOld_r[1] & pinSync_r[1];
	wire ext0Evt = (ext0Fall & extZeroEdgeSel[0]) | (ext0Rise & extZeroEdgeSel[1]);
	wire ext1Evt = (ext1Fall & extOneEdgeSel[0]) | (ext1Rise & extOneEdgeSel[1]);

	// ****************************************************************
	// sources, enables and selection
	// ****************************************************************
	logic [7:0] ctrlA_r, ctrlB_r;
	// source order is priority order, index 0 highest
	wire [NUM_SRC-1:0] srcEvt = {rtcTimeout, adcDone, timebaseTimeout,
		timerOvf, ext1Evt, ext0Evt};
	wire [NUM_SRC-1:0] pending = {ctrlB_r[PND_RTC_BIT], ctrlB_r[PND_ADC_BIT],
		ctrlB_r[PND_TB_BIT], ctrlA_r[PND_TMR_BIT], ctrlA_r[PND_EXT1_BIT],
		ctrlA_r[PND_EXT0_BIT]};
	wire [NUM_SRC-1:0] srcEn = {ctrlB_r[EN_RTC_BIT], ctrlB_r[EN_ADC_BIT],
		ctrlB_r[EN_TB_BIT], ctrlA_r[EN_TMR_BIT], ctrlA_r[EN_EXT1_BIT],
		ctrlA_r[EN_EXT0_BIT]};
	wire globalIrqEnable = ctrlA_r[GIE_BIT];
	wire stackFull = (stackDepth >= 4'(DEPTH));
	// enables gate service, not the flags themselves
	wire [NUM_SRC-1:0] eligible = pending & srcEn &
		{NUM_SRC{globalIrqEnable}};
	// acknowledge only at phase two and only with room on stack
	wire ackNow = (|eligible) & ~stackFull & isPhaseTwo;
	logic [NUM_SRC-1:0] grant;
	// lowest index wins
	always_comb
	begin
		grant = '0;
		for (int i = NUM_SRC - 1; i >= 0; i--)
			if (eligible[i])
				grant = 6'(1) << i;
	end
	wire [NUM_SRC-1:0] ackVec = grant & {NUM_SRC{ackNow}};
	logic [11:0] vecSel;
	// vector table per source
	always_comb
	begin
		vecSel = VEC_RTC;
		if (grant[0])
			vecSel = VEC_EXT0;
		else if (grant[1])
			vecSel = VEC_EXT1;
		else if (grant[2])
			vecSel = VEC_TMR;
		else if (grant[3])
			vecSel = VEC_TB;
		else if (grant[4])
			vecSel = VEC_ADC;
	end

	// ****************************************************************
	// control registers
	// ****************************************************************
	wire wrA = memReq.wrEn & (memReq.addr == CTRL_A_ADDR);
	wire wrB = memReq.wrEn & (memReq.addr == CTRL_B_ADDR);
	// unused bits never store, so they always read back as zero
	wire [7:0] wdataA = memReq.wdata & CTRL_WMASK;
	wire [7:0] wdataB = memReq.wdata & CTRL_B_WMASK;
	logic [7:0] ctrlA_nxt, ctrlB_nxt;
	logic [NUM_SRC-1:0] pend_nxt;
	// write first, then ack clears, then hardware sets win over both
	always_comb
	begin
		ctrlA_nxt = wrA ? wdataA : ctrlA_r;
		ctrlB_nxt = wrB ? wdataB : ctrlB_r;
		// interrupt exit re-opens, subroutine exit leaves it alone
		if (interruptExitInstr)
			ctrlA_nxt[GIE_BIT] = 1'b1;
		// acknowledge closes the global gate
		if (ackNow)
			ctrlA_nxt[GIE_BIT] = 1'b0;
		pend_nxt = {ctrlB_nxt[PND_RTC_BIT], ctrlB_nxt[PND_ADC_BIT],
			ctrlB_nxt[PND_TB_BIT], ctrlA_nxt[PND_TMR_BIT],
			ctrlA_nxt[PND_EXT1_BIT], ctrlA_nxt[PND_EXT0_BIT]};
		// flags held until serviced or written, a new event wins
		pend_nxt = (pend_nxt & ~ackVec) | srcEvt;
		ctrlA_nxt[PND_EXT0_BIT] = pend_nxt[0];
		ctrlA_nxt[PND_EXT1_BIT] = pend_nxt[1];
		ctrlA_nxt[PND_TMR_BIT] = pend_nxt[2];
		ctrlB_nxt[PND_TB_BIT] = pend_nxt[3];
		ctrlB_nxt[PND_ADC_BIT] = pend_nxt[4];
		ctrlB_nxt[PND_RTC_BIT] = pend_nxt[5];
	end
	always_ff @(posedge clk_sys or negedge rst_n)
		if (!rst_n)
		begin
			ctrlA_r <= CTRL_A_RESET;
			ctrlB_r <= CTRL_B_RESET;
		end
		else
		begin
			ctrlA_r <= ctrlA_nxt;
			ctrlB_r <= ctrlB_nxt;
		end

	// ****************************************************************
	// read port, call and wake outputs
	// ****************************************************************
	logic [7:0] rdData_r;
	logic rdHit_r;
	irq_call_t irqCall_r;
	logic wakeUp_r;
	wire rdA = memReq.rdEn & (memReq.addr == CTRL_A_ADDR);
	wire rdB = memReq.rdEn & (memReq.addr == CTRL_B_ADDR);
	wire [7:0] rdMux = rdA ? ctrlA_r : (rdB ? ctrlB_r : 8'h00);
	// flags set before halting do not wake, so only fresh events count
	wire wakeEvt = halted & (|(srcEvt & ~pending));
	always_ff @(posedge clk_sys or negedge rst_n)
		if (!rst_n)
		begin
			rdData_r <= 8'h00;
			rdHit_r <= 1'b0;
			irqCall_r <= '0;
			wakeUp_r <= 1'b0;
		end
		else
		begin
			rdData_r <= rdMux;
			rdHit_r <= rdA | rdB;
			// a one-cycle call; sequencer pushes pc alone
			irqCall_r.call <= ackNow;
			irqCall_r.vector <= ackNow ? vecSel : irqCall_r.vector;
			wakeUp_r <= wakeEvt;
		end
	assign rdData = rdData_r;
	assign rdHit = rdHit_r;
	assign irqCall = irqCall_r;
	assign wakeUp = wakeUp_r;

	// ****************************************************************
	// assertions
	// ****************************************************************
	ack_gie_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ackNow |=> !ctrlA_r[GIE_BIT])
		else $error("global enable not cleared on acknowledge");
	full_stack_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		stackFull |=> !irqCall_r.call)
		else $error("call issued with full stack");
	phase_two_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		irqCall_r.call |-> $past(phase_r) == PHASE_TWO)
		else $error("call outside phase two");
	ext0_vector_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(ackNow && eligible[0]) |=> irqCall_r.vector == 12'h004)
		else $error("wrong vector for pin zero");
	pend_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(ackNow && grant[2] && !timerOvf && !wrA)
		|=> !ctrlA_r[PND_TMR_BIT])
		else $error("timer flag not cleared on acknowledge");
	rtc_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		rtcTimeout |=> ctrlB_r[PND_RTC_BIT])
		else $error("rtc flag not set");
	masked_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!globalIrqEnable |=> !irqCall_r.call)
		else $error("call while globally masked");
	exit_gie_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(interruptExitInstr && !ackNow) |=> ctrlA_r[GIE_BIT])
		else $error("interrupt exit did not set global enable");
	phase_cycle_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		isPhaseTwo |=> !isPhaseTwo [*3] ##1 isPhaseTwo)
		else $error("phase two not every fourth clock");

	// vector per granted source, one cycle after the acknowledge
	ext1_vector_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(ackNow && grant[1]) |=> irqCall_r.vector == 12'h008)
		else $error("wrong vector for pin one");
	tmr_vector_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(ackNow && grant[2]) |=> irqCall_r.vector == 12'h00C)
		else $error("wrong vector for timer");
	tb_vector_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(ackNow && grant[3]) |=> irqCall_r.vector == 12'h010)
		else $error("wrong vector for time base");
	adc_vector_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(ackNow && grant[4]) |=> irqCall_r.vector == 12'h014)
		else $error("wrong vector for adc");
	rtc_vector_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(ackNow && grant[5]) |=> irqCall_r.vector == 12'h018)
		else $error("wrong vector for rtc");
	prio_one_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(ackNow && eligible[1] && !eligible[0])
		|=> irqCall_r.vector == 12'h008)
		else $error("pin one not second in priority");
	grant_one_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$onehot0(grant))
		else $error("more than one source granted");

	// the call is a single pulse and the vector holds between calls
	call_pulse_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		irqCall_r.call |=> !irqCall_r.call)
		else $error("call longer than one cycle");
	vec_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!irqCall_r.call |-> irqCall_r.vector == $past(irqCall_r.vector))
		else $error("vector moved without a call");
	call_gie_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		irqCall_r.call |-> $past(globalIrqEnable))
		else $error("call without global enable");

	// hardware events set their flags on the next clock
	tmr_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		timerOvf |=> ctrlA_r[PND_TMR_BIT])
		else $error("timer flag not set");
	tb_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		timebaseTimeout |=> ctrlB_r[PND_TB_BIT])
		else $error("time base flag not set");
	adc_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		adcDone |=> ctrlB_r[PND_ADC_BIT])
		else $error("adc flag not set");
	ext0_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ext0Evt |=> ctrlA_r[PND_EXT0_BIT])
		else $error("pin zero flag not set");
	ext1_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ext1Evt |=> ctrlA_r[PND_EXT1_BIT])
		else $error("pin one flag not set");

	// flags stay until serviced or written, and clear on service
	hold_tmr_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(ctrlA_r[PND_TMR_BIT] && !ackVec[2] && !wrA)
		|=> ctrlA_r[PND_TMR_BIT])
		else $error("timer flag dropped");
	hold_rtc_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(ctrlB_r[PND_RTC_BIT] && !ackVec[5] && !wrB)
		|=> ctrlB_r[PND_RTC_BIT])
		else $error("rtc flag dropped");
	ext0_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(ackNow && grant[0] && !ext0Evt && !wrA)
		|=> !ctrlA_r[PND_EXT0_BIT])
		else $error("pin zero flag not cleared on acknowledge");
	rtc_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(ackNow && grant[5] && !rtcTimeout && !wrB)
		|=> !ctrlB_r[PND_RTC_BIT])
		else $error("rtc flag not cleared on acknowledge");
	full_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(stackFull && (|eligible) && !wrA && !wrB) |=> (|pending))
		else $error("request lost while stack full");

	// global enable: written by software, kept by subroutine exit
	gie_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(wrA && !ackNow && !interruptExitInstr)
		|=> ctrlA_r[GIE_BIT] == $past(memReq.wdata[GIE_BIT]))
		else $error("global enable not written");
	sub_exit_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(subroutineExitInstr && !interruptExitInstr && !wrA && !ackNow)
		|=> ctrlA_r[GIE_BIT] == $past(ctrlA_r[GIE_BIT]))
		else $error("subroutine exit changed global enable");

	// wake from halt on fresh events only
	wake_rtc_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(halted && rtcTimeout && !ctrlB_r[PND_RTC_BIT]) |=> wakeUp_r)
		else $error("rtc event did not wake");
	wake_tmr_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(halted && timerOvf && !ctrlA_r[PND_TMR_BIT]) |=> wakeUp_r)
		else $error("timer event did not wake");
	no_wake_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!halted |=> !wakeUp_r)
		else $error("wake while running");

	// read port and unused bits
	read_a_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		rdA |=> rdData_r == $past(ctrlA_r))
		else $error("wrong read data for control a");
	read_b_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		rdB |=> rdData_r == $past(ctrlB_r))
		else $error("wrong read data for control b");
	rd_hit_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(rdA || rdB) |=> rdHit_r)
		else $error("read hit missing");
	unused_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!ctrlA_r[7] && !ctrlB_r[7] && !ctrlB_r[3])
		else $error("unused control bit set");
	phase_wrap_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		phase_r == 2'h3 |=> phase_r == 2'h0)
		else $error("phase counter did not wrap");
endmodule : six_source_vectored_irq_unit

// >>> src/irq_unit_pkg.sv
// package for the six-source vectored interrupt unit
// assumes an 8-bit data memory bus and a 12-bit program counter
package irq_unit_pkg;
	localparam logic [7:0] CTRL_A_ADDR = 8'h0B;
	localparam logic [7:0] CTRL_B_ADDR = 8'h1E;
	// irq_control_a fields
	localparam int GIE_BIT = 0;
	localparam int EN_EXT0_BIT = 1;
	localparam int EN_EXT1_BIT = 2;
	localparam int EN_TMR_BIT = 3;
	localparam int PND_EXT0_BIT = 4;
	localparam int PND_EXT1_BIT = 5;
	localparam int PND_TMR_BIT = 6;
	// irq_control_b fields
	localparam int EN_TB_BIT = 0;
	localparam int EN_ADC_BIT = 1;
	localparam int EN_RTC_BIT = 2;
	localparam int PND_TB_BIT = 4;
	localparam int PND_ADC_BIT = 5;
	localparam int PND_RTC_BIT = 6;
	localparam logic [7:0] CTRL_A_RESET = 8'h00;
	localparam logic [7:0] CTRL_B_RESET = 8'h00;
	localparam logic [7:0] CTRL_WMASK = 8'h7F;
	// bit 3 of control b is unused and reads back as zero
	localparam logic [7:0] CTRL_B_WMASK = 8'h77;
	localparam int NUM_SRC = 6;
	localparam int STACK_LEVELS = 8;
	localparam int PHASES = 4;
	localparam logic [1:0] PHASE_TWO = 2'h1;
	localparam logic [11:0] VEC_EXT0 = 12'h004;
	localparam logic [11:0] VEC_EXT1 = 12'h008;
	localparam logic [11:0] VEC_TMR = 12'h00C;
	localparam logic [11:0] VEC_TB = 12'h010;
	localparam logic [11:0] VEC_ADC = 12'h014;
	localparam logic [11:0] VEC_RTC = 12'h018;
	typedef struct packed {
		logic wrEn;
		logic rdEn;
		logic [7:0] addr;
		logic [7:0] wdata;
	} mem_req_t;
	typedef struct packed {
		logic call;
		logic [11:0] vector;
	} irq_call_t;
endpackage : irq_unit_pkg

// >>> verification/seq_model.sv
// sequencer and stack model facing the interrupt unit
// assumes the bench commands software calls and returns as pulses
`timescale 1ns/10ps
module seq_model
	import irq_unit_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire irq_call_t irqCall,
	input wire logic doCall,
	input wire logic doRetIrq,
	input wire logic doRetSub,
	output logic [3:0] stackDepth,
	output logic interruptExitInstr,
	output logic subroutineExitInstr
);
	// ****************************************
	// returns pass straight to the unit
	// ****************************************
	assign interruptExitInstr = doRetIrq;
	assign subroutineExitInstr = doRetSub;
	wire push = irqCall.call | doCall;
	wire pop = doRetIrq | doRetSub;
	// only the pc goes on the stack; a push when full leaves the depth at eight
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			stackDepth <= 4'h0;
		else if (push && !pop && stackDepth < 4'h8)
			stackDepth <= stackDepth + 4'h1;
		else if (pop && !push && stackDepth != 4'h0)
			stackDepth <= stackDepth - 4'h1;
	end
endmodule : seq_model

// >>> verification/tb_six_source_vectored_irq_unit.sv
// bench for the vectored interrupt unit: registers, priority, stack
// assumes seq_model stands in for the sequencer and its stack
`timescale 1ns/10ps
module tb_six_source_vectored_irq_unit import irq_unit_pkg::*; ();
	// ****************************************
	// signals and instances
	// ****************************************
	logic clk_sys = 0, rst_n = 0, p0 = 0, p1 = 0, halted = 0;
	logic tOvf, tBase, adc, rtc, doCall, doRetIrq, doRetSub, rdHit;
	logic wakeUp, phaseTwoClock, iExit, sExit, sawWake = 0;
	logic [1:0] phase, lastPh, sel0 = 2'h3, sel1 = 2'h3;
	logic prevP2 = 0, lastP2;
	logic [3:0] stackDepth;
	logic [7:0] rdData;
	logic [11:0] lastVec;
	mem_req_t memReq;
	irq_call_t irqCall;
	int n_mismatch = 0, checks = 0, cyc = 0, nCall = 0, n0;
	logic [11:0] vecs [6] = '{VEC_EXT0, VEC_EXT1, VEC_TMR, VEC_TB,
		VEC_ADC, VEC_RTC};
	six_source_vectored_irq_unit i_six_source_vectored_irq_unit (
		.clk_sys(clk_sys), .rst_n(rst_n), .memReq(memReq),
		.rdData(rdData), .rdHit(rdHit), .extPinZero(p0),
		.extPinOne(p1), .extZeroEdgeSel(sel0), .extOneEdgeSel(sel1),
		.timerOvf(tOvf), .timebaseTimeout(tBase), .adcDone(adc),
		.rtcTimeout(rtc), .interruptExitInstr(iExit),
		.subroutineExitInstr(sExit), .stackDepth(stackDepth),
		.halted(halted), .irqCall(irqCall), .wakeUp(wakeUp),
		.phaseTwoClock(phaseTwoClock), .phase(phase));
	seq_model i_seq_model (.clk_sys(clk_sys), .rst_n(rst_n),
		.irqCall(irqCall), .doCall(doCall), .doRetIrq(doRetIrq),
		.doRetSub(doRetSub), .stackDepth(stackDepth),
		.interruptExitInstr(iExit), .subroutineExitInstr(sExit));
	always #25 clk_sys = ~clk_sys;
	// call and wake monitor, plus the hang guard
	always @(posedge clk_sys)
	begin
		cyc++;
		if (irqCall.call === 1'b1)
		begin
			nCall++;
			lastVec = irqCall.vector;
			lastPh = phase;
			lastP2 = prevP2;
		end
		prevP2 = phaseTwoClock;
		if (wakeUp === 1'b1)
			sawWake = 1;
		if (cyc > 2000)
		begin
			n_mismatch++;
			tally_and_finish();
		end
	end
	// ****************************************
	// access tasks
	// ****************************************
	task chk(input logic [11:0] got, input logic [11:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("wrong value at %0t: %h, expected %h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys) #5;
		memReq = '{1'b1, 1'b0, a, d};
		@(posedge clk_sys) #5;
		memReq = '0;
	endtask : wr
	task rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_sys) #5;
		memReq = '{1'b0, 1'b1, a, 8'h00};
		@(posedge clk_sys) #5;
		memReq = '0;
		chk({4'h0, rdData}, {4'h0, exp});
		chk({11'h000, rdHit},
			{11'h000, (a == CTRL_A_ADDR || a == CTRL_B_ADDR)});
	endtask : rd
	// bit 0/1 toggle a pin, bits 2..5 pulse timer, base, adc, rtc
	task ev(input logic [5:0] m);
		@(posedge clk_sys) #5;
		{rtc, adc, tBase, tOvf} = m[5:2];
		p0 ^= m[0];
		p1 ^= m[1];
		@(posedge clk_sys) #5;
		{rtc, adc, tBase, tOvf} = 4'h0;
	endtask : ev
	task sq(input logic ri, input logic rs);
		@(posedge clk_sys) #5;
		{doRetIrq, doRetSub} = {ri, rs};
		@(posedge clk_sys) #5;
		{doRetIrq, doRetSub} = 2'h0;
	endtask : sq
	// a call answers within three instruction cycles
	task waitCall(input logic [11:0] v);
		n0 = nCall;
		for (int i = 0; i < 12 && nCall == n0; i++)
			@(posedge clk_sys) #1;
		chk(nCall == n0 + 1 ? lastVec : 12'hFFF, v);
		chk({10'h000, lastPh}, 12'h002);
		chk({11'h000, lastP2}, 12'h001);
	endtask : waitCall
	task tally_and_finish;
		if (n_mismatch == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : tally_and_finish
	// ****************************************
	// test sequence
	// ****************************************
	initial
	begin
		memReq = '0;
		{tOvf, tBase, adc, rtc, doCall, doRetIrq, doRetSub} = 7'h00;
		repeat (3) @(posedge clk_sys);
		#5 rst_n = 1;
		rd(CTRL_A_ADDR, CTRL_A_RESET);
		rd(CTRL_B_ADDR, CTRL_B_RESET);
		rd(8'h0C, 8'h00);
		wr(CTRL_B_ADDR, 8'h08);
		rd(CTRL_B_ADDR, 8'h00);
		wr(CTRL_A_ADDR, 8'hFE);
		rd(CTRL_A_ADDR, 8'h7E);
		wr(CTRL_A_ADDR, 8'h00);
		rd(CTRL_A_ADDR, 8'h00);
		ev(6'h3F);
		repeat (6) @(posedge clk_sys);
		rd(CTRL_A_ADDR, 8'h70);
		rd(CTRL_B_ADDR, 8'h70);
		wr(CTRL_B_ADDR, 8'h77);
		wr(CTRL_A_ADDR, 8'h7F);
		waitCall(VEC_EXT0);
		rd(CTRL_A_ADDR, 8'h6E);
		for (int i = 1; i < 6; i++)
		begin
			sq(1'b1, 1'b0);
			waitCall(vecs[i]);
		end
		sel0 = 2'h2;
		ev(6'h01);
		repeat (4) @(posedge clk_sys);
		rd(CTRL_A_ADDR, 8'h0E);
		sel0 = 2'h1;
		ev(6'h01);
		repeat (4) @(posedge clk_sys);
		rd(CTRL_A_ADDR, 8'h0E);
		ev(6'h01);
		repeat (4) @(posedge clk_sys);
		rd(CTRL_A_ADDR, 8'h1E);
		rd(CTRL_B_ADDR, 8'h07);
		@(posedge clk_sys) #5 doCall = 1;
		repeat (8) @(posedge clk_sys);
		#5 doCall = 0;
		wr(CTRL_A_ADDR, 8'h0F);
		ev(6'h04);
		n0 = nCall;
		repeat (12) @(posedge clk_sys);
		chk(12'(nCall - n0), 12'h000);
		rd(CTRL_A_ADDR, 8'h4F);
		sq(1'b0, 1'b1);
		waitCall(VEC_TMR);
		sq(1'b0, 1'b1);
		rd(CTRL_A_ADDR, 8'h0E);
		ev(6'h08);
		wr(CTRL_A_ADDR, 8'h0F);
		waitCall(VEC_TB);
		halted = 1;
		ev(6'h10);
		repeat (4) @(posedge clk_sys);
		chk({11'h000, sawWake}, 12'h001);
		tally_and_finish();
	end
endmodule : tb_six_source_vectored_irq_unit
